// *** logic/boot_image_loader.sv ***
`timescale 1ns/10ps
`default_nettype none

// Byte FIFO between the image source and the parser.
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb begin
		push = i_in_valid && o_in_ready;
		pop = o_out_valid && i_out_ready;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		o_in_ready = cnt_q != (AW+1)'(DEPTH);
		o_out_valid = cnt_q != '0;
		o_out_data = mem_q[rp_q];
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (i_ce) begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			if (push) begin
				mem_q[wp_q] <= i_in_data;
			end
		end
	end
endmodule

// Behaviour
// - While reset is held low the tile stays in reset and every general pin is pulled down.
// - After reset is released an internal reset period of 15 to 150 us runs before boot.
// - Security bit 5 set selects boot from OTP, otherwise from the embedded serial flash.
// - The image opens with a 32-bit word count s followed by s times four program bytes.
// - A 32-bit trailer follows; the value 0x0D15AB1E skips the check, else it is the CRC.
// - Word count and trailer are little-endian, least significant byte first.
// - The program is written from the lowest RAM address and execution starts there.
// - The CRC covers the word count and all program bytes but not the trailer.
// - The CRC is the reflected polynomial 0xEDB88320, bytes taken LSB first.
// - The CRC starts at all ones and the final value is inverted before comparison.
// - OTP boot fetches from OTP address 0 and bypasses the boot ROM.
// - The security register is loaded from OTP before the boot source is chosen.
module boot_image_loader import boot_pkg::*; #(
	parameter int RST_CYCLES = RST_PROC_CYC,
	parameter int GPIO_COUNT = 16
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	output qspi_pins_s o_qspi,
	input wire logic [3:0] i_qspi_dq,
	output logic o_otp_rd,
	output logic [10:0] o_otp_addr,
	input wire logic i_otp_valid,
	input wire logic [31:0] i_otp_data,
	output ram_wr_s o_ram,
	input wire logic i_ram_ready,
	output logic [GPIO_COUNT-1:0] o_gpio_pulldown,
	output logic o_core_rst_n,
	output logic [31:0] o_start_addr,
	output logic o_boot_done,
	output logic o_boot_fail
);
	initial begin
		if (RST_CYCLES < 1 || RST_CYCLES > 65535) $error("RST_CYCLES out of range");
		if (GPIO_COUNT < 1) $error("GPIO_COUNT must be positive");
	end

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h000000, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	typedef enum logic [5:0] {
		B_WAIT = 6'h01, B_SEC = 6'h02, B_LOAD = 6'h04, B_RUN = 6'h08, B_FAIL = 6'h10
	} boot_e;
	typedef enum logic [3:0] {
		Q_IDLE = 4'h1, Q_HDR = 4'h2, Q_DUMMY = 4'h4, Q_DATA = 4'h8
	} qspi_e;
	typedef enum logic [3:0] {
		P_LEN = 4'h1, P_BODY = 4'h2, P_TRL = 4'h4, P_DONE = 4'h8
	} parse_e;

	// Pin inputs pass two flops; only the second is read.
	logic [3:0] dq_meta_q, dq_sync_q;
	always_ff @(posedge i_mclk) begin
		if (i_ce) begin
			dq_meta_q <= i_qspi_dq;
			dq_sync_q <= dq_meta_q;
		end
	end

	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [7:0] fifo_in_data, fifo_out_data;

	boot_e b_q, b_d;
	logic [15:0] wait_q, wait_d;
	logic [31:0] sec_q, sec_d;
	logic secure;
	logic p_done, p_ok;
	logic core_rst_n_d, done_d, fail_d;

	always_comb begin
		b_d = b_q;
		wait_d = wait_q;
		sec_d = sec_q;
		core_rst_n_d = 1'b0;
		done_d = 1'b0;
		fail_d = 1'b0;
		unique case (b_q)
			B_WAIT: begin
				wait_d = wait_q + 16'h0001;
				if (wait_q == 16'(RST_CYCLES - 1)) b_d = B_SEC;
			end
			B_SEC: begin
				if (i_otp_valid) begin
					sec_d = i_otp_data;
					b_d = B_LOAD;
				end
			end
			B_LOAD: begin
				if (p_done && !o_ram.we) b_d = p_ok ? B_RUN : B_FAIL;
			end
			B_RUN: begin
				core_rst_n_d = 1'b1;
				done_d = 1'b1;
			end
			B_FAIL: begin
				fail_d = 1'b1;
				done_d = 1'b1;
			end
		endcase
		secure = sec_q[SEC_SECURE_BOOT_BIT];
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			b_q <= B_WAIT;
			wait_q <= '0;
			sec_q <= '0;
			o_gpio_pulldown <= '1;
			o_core_rst_n <= 1'b0;
			o_start_addr <= RAM_BASE_ADDR;
			o_boot_done <= 1'b0;
			o_boot_fail <= 1'b0;
		end else if (i_ce) begin
			b_q <= b_d;
			wait_q <= wait_d;
			sec_q <= sec_d;
			o_gpio_pulldown <= '0;
			o_core_rst_n <= core_rst_n_d;
			o_start_addr <= RAM_BASE_ADDR;
			o_boot_done <= done_d;
			o_boot_fail <= fail_d;
		end
	end

	// Quad read engine. Each SCLK period is four mclk cycles so the synchronised
	// data is settled at the sample phase; a byte is only started when the FIFO
	// has room, which is how back-pressure reaches the flash.
	qspi_e q_q, q_d;
	logic [1:0] ph_q, ph_d;
	logic [5:0] bit_q, bit_d;
	logic [31:0] hdr_q, hdr_d;
	logic [3:0] nib_q, nib_d;
	logic half_q, half_d, push_q, push_d;
	logic [7:0] pdata_q, pdata_d;
	qspi_pins_s pins_d;
	logic stall;

	always_comb begin
		q_d = q_q;
		ph_d = ph_q + 2'h1;
		bit_d = bit_q;
		hdr_d = hdr_q;
		nib_d = nib_q;
		half_d = half_q;
		push_d = 1'b0;
		pdata_d = pdata_q;
		pins_d = o_qspi;
		stall = 1'b0;
		unique case (q_q)
			Q_IDLE: begin
				ph_d = QSPI_PH_DRIVE;
				pins_d = '{sclk: 1'b0, cs_n: 1'b1, dq: 4'h0, dq_oe: 4'h0};
				if (b_q == B_LOAD && !secure && !p_done) begin
					q_d = Q_HDR;
					hdr_d = {QSPI_CMD_QREAD, FLASH_START_ADDR};
					bit_d = '0;
					pins_d.cs_n = 1'b0;
					pins_d.dq_oe = 4'h1;
				end
			end
			Q_HDR: begin
				if (ph_q == QSPI_PH_DRIVE) pins_d.dq = {3'h0, hdr_q[31]};
				if (ph_q == QSPI_PH_SAMPLE) begin
					hdr_d = {hdr_q[30:0], 1'b0};
					bit_d = bit_q + 6'h01;
					if (bit_q == QSPI_HDR_LAST) begin
						q_d = Q_DUMMY;
						bit_d = '0;
						pins_d.dq_oe = 4'h0;
					end
				end
			end
			Q_DUMMY: begin
				if (ph_q == QSPI_PH_SAMPLE) begin
					bit_d = bit_q + 6'h01;
					if (bit_q == QSPI_DUMMY_LAST) begin
						q_d = Q_DATA;
						half_d = 1'b0;
					end
				end
			end
			Q_DATA: begin
				// The byte before is still entering the FIFO in this cycle, so its room is
				// only known one cycle later; without the wait the last free slot is overrun.
				stall = ph_q == QSPI_PH_DRIVE && !half_q && (!fifo_in_ready || push_q);
				if (stall) ph_d = ph_q;
				if (ph_q == QSPI_PH_SAMPLE) begin
					nib_d = dq_sync_q;
					half_d = !half_q;
					if (half_q) begin
						push_d = 1'b1;
						pdata_d = {nib_q, dq_sync_q};
					end
				end
			end
		endcase
		if (q_q != Q_IDLE) pins_d.sclk = ph_d[1];
		if (p_done && q_q != Q_IDLE) begin
			q_d = Q_IDLE;
			pins_d = '{sclk: 1'b0, cs_n: 1'b1, dq: 4'h0, dq_oe: 4'h0};
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			q_q <= Q_IDLE;
			ph_q <= '0;
			bit_q <= '0;
			hdr_q <= '0;
			nib_q <= '0;
			half_q <= 1'b0;
			push_q <= 1'b0;
			pdata_q <= '0;
			o_qspi <= '{sclk: 1'b0, cs_n: 1'b1, dq: 4'h0, dq_oe: 4'h0};
		end else if (i_ce) begin
			q_q <= q_d;
			ph_q <= ph_d;
			bit_q <= bit_d;
			hdr_q <= hdr_d;
			nib_q <= nib_d;
			half_q <= half_d;
			push_q <= push_d;
			pdata_q <= pdata_d;
			o_qspi <= pins_d;
		end
	end

	// OTP reader: security row first, then image words split LSB first.
	logic [10:0] oaddr_d;
	logic ord_d;
	logic [31:0] ow_q, ow_d;
	logic [2:0] ob_q, ob_d;

	always_comb begin
		oaddr_d = o_otp_addr;
		ord_d = o_otp_rd;
		ow_d = ow_q;
		ob_d = ob_q;
		if (b_q == B_SEC) begin
			oaddr_d = OTP_SEC_ROW;
			ord_d = !i_otp_valid;
			if (i_otp_valid) oaddr_d = OTP_IMAGE_ROW;
		end else if (b_q == B_LOAD && secure && !p_done) begin
			if (ob_q != 3'h0 && fifo_in_ready) begin
				ow_d = {8'h00, ow_q[31:8]};
				ob_d = ob_q - 3'h1;
			end
			if (i_otp_valid && o_otp_rd) begin
				ord_d = 1'b0;
				ow_d = i_otp_data;
				ob_d = 3'h4;
				oaddr_d = o_otp_addr + 11'h001;
			end else if (ob_q == 3'h0 && !o_otp_rd) begin
				ord_d = 1'b1;
			end
		end else begin
			ord_d = 1'b0;
		end
		fifo_in_valid = secure ? ob_q != 3'h0 : push_q;
		fifo_in_data = secure ? ow_q[7:0] : pdata_q;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_otp_addr <= OTP_SEC_ROW;
			o_otp_rd <= 1'b0;
			ow_q <= '0;
			ob_q <= '0;
		end else if (i_ce) begin
			o_otp_addr <= oaddr_d;
			o_otp_rd <= ord_d;
			ow_q <= ow_d;
			ob_q <= ob_d;
		end
	end

	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) u_fifo (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_in_valid(fifo_in_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(fifo_in_data),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_out_data)
	);

	// Image parser. A pending RAM write that is not yet accepted stops the
	// parser draining the FIFO, so a slow RAM eventually stalls the source.
	parse_e p_q, p_d;
	logic [1:0] bc_q, bc_d;
	logic [31:0] acc_q, acc_d, left_q, left_d, crc_q, crc_d, word;
	logic ok_q, ok_d;
	ram_wr_s ram_d;

	always_comb begin
		p_d = p_q;
		bc_d = bc_q;
		acc_d = acc_q;
		left_d = left_q;
		crc_d = crc_q;
		ok_d = ok_q;
		ram_d = o_ram;
		if (o_ram.we && i_ram_ready) ram_d.we = 1'b0;
		fifo_pop = b_q == B_LOAD && p_q != P_DONE && !(o_ram.we && !i_ram_ready);
		word = {fifo_out_data, acc_q[31:8]};
		if (fifo_pop && fifo_out_valid) begin
			acc_d = word;
			bc_d = bc_q + 2'h1;
			if (p_q != P_TRL) crc_d = crc_byte(crc_q, fifo_out_data);
			if (bc_q == 2'h3) begin
				unique case (p_q)
					P_LEN: begin
						left_d = word;
						p_d = word == 32'h00000000 ? P_TRL : P_BODY;
					end
					P_BODY: begin
						ram_d.we = 1'b1;
						ram_d.data = word;
						if (ram_d.we && o_ram.we) ram_d.addr = o_ram.addr;
						left_d = left_q - 32'h00000001;
						if (left_q == 32'h00000001) p_d = P_TRL;
					end
					P_TRL: begin
						p_d = P_DONE;
						ok_d = word == CRC_SKIP_MARK || word == ~crc_q;
					end
					P_DONE: begin
						p_d = P_DONE;
					end
				endcase
			end
		end
		p_done = p_q == P_DONE;
		p_ok = ok_q;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			p_q <= P_LEN;
			bc_q <= '0;
			acc_q <= '0;
			left_q <= '0;
			crc_q <= CRC_INIT;
			ok_q <= 1'b0;
			o_ram <= '{we: 1'b0, addr: RAM_BASE_ADDR[15:0], data: 32'h00000000};
		end else if (i_ce) begin
			p_q <= p_d;
			bc_q <= bc_d;
			acc_q <= acc_d;
			left_q <= left_d;
			crc_q <= crc_d;
			ok_q <= ok_d;
			o_ram.we <= ram_d.we;
			o_ram.data <= ram_d.data;
			if (o_ram.we && i_ram_ready) begin
				o_ram.addr <= o_ram.addr + 16'h0001;
			end
		end
	end

endmodule

`default_nettype wire

// *** logic/boot_pkg.sv ***
package boot_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_PROC_MIN_US = 15;
	localparam int RST_PROC_MAX_US = 150;
	localparam int RST_PROC_CYC = (RST_PROC_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_SKIP_MARK = 32'h0D15AB1E;

	localparam int SEC_SECURE_BOOT_BIT = 5;
	localparam logic [10:0] OTP_SEC_ROW = 11'h7FF;
	localparam logic [10:0] OTP_IMAGE_ROW = 11'h000;

	localparam logic [7:0] QSPI_CMD_QREAD = 8'h6B;
	localparam logic [23:0] FLASH_START_ADDR = 24'h000000;
	localparam logic [5:0] QSPI_HDR_LAST = 6'h1F;
	localparam logic [5:0] QSPI_DUMMY_LAST = 6'h07;
	localparam logic [1:0] QSPI_PH_DRIVE = 2'h0;
	localparam logic [1:0] QSPI_PH_SAMPLE = 2'h3;

	localparam logic [31:0] RAM_BASE_ADDR = 32'h00000000;
	localparam int FIFO_WORDS = 16;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic [3:0] dq;
		logic [3:0] dq_oe;
	} qspi_pins_s;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [31:0] data;
	} ram_wr_s;

endpackage

// *** testbench/boot_loader_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

module boot_loader_chk import boot_pkg::*; #(
	parameter int RST_CYCLES = 4,
	parameter int GPIO_COUNT = 16
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire qspi_pins_s o_qspi,
	input wire logic o_otp_rd,
	input wire logic [10:0] o_otp_addr,
	input wire logic i_otp_valid,
	input wire logic [31:0] i_otp_data,
	input wire ram_wr_s o_ram,
	input wire logic i_ram_ready,
	input wire logic [GPIO_COUNT-1:0] o_gpio_pulldown,
	input wire logic o_core_rst_n,
	input wire logic [31:0] o_start_addr,
	input wire logic o_boot_done,
	input wire logic o_boot_fail
);
	int cnt_q;
	logic sec_seen_q;
	logic sec5_q;

	// Mirrors security bit 5 from the first OTP answer so the chosen source can be judged.
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			cnt_q <= 0;
			sec_seen_q <= 1'b0;
			sec5_q <= 1'b0;
		end else begin
			if (cnt_q < 100000) begin
				cnt_q <= cnt_q + 1;
			end
			if (o_otp_rd && i_otp_valid && !sec_seen_q) begin
				sec_seen_q <= 1'b1;
				sec5_q <= i_otp_data[SEC_SECURE_BOOT_BIT];
			end
		end
	end

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);

	chk_rst_pull_low: assert property (@(posedge i_mclk) disable iff (1'b0)
		!i_nrst |=> (&o_gpio_pulldown) && !o_core_rst_n)
		else $error("pulldown or core reset wrong in reset");
	chk_pull_release: assert property ($rose(i_nrst) |=> o_gpio_pulldown == '0)
		else $error("pulldown kept after reset");
	chk_rst_wait: assert property (o_otp_rd |-> cnt_q >= RST_CYCLES)
		else $error("boot began before reset period");
	chk_sec_first: assert property (o_otp_rd && !sec_seen_q |-> o_otp_addr == OTP_SEC_ROW)
		else $error("security word not read first");
	chk_flash_src: assert property (!o_qspi.cs_n |-> sec_seen_q && !sec5_q)
		else $error("flash selected wrongly");
	chk_otp_src: assert property (o_otp_rd && sec_seen_q |-> sec5_q)
		else $error("image read from OTP wrongly");
	chk_sclk_shape: assert property ($rose(o_qspi.sclk) |=>
		(o_qspi.sclk || o_qspi.cs_n) ##1 !o_qspi.sclk)
		else $error("serial clock high phase wrong");
	chk_ram_hold: assert property (o_ram.we && !i_ram_ready |=> o_ram.we &&
		$stable(o_ram.addr) && $stable(o_ram.data))
		else $error("ram write dropped before accept");
	chk_ram_step: assert property (o_ram.we && i_ram_ready |=>
		o_ram.addr == $past(o_ram.addr) + 16'h1)
		else $error("ram address did not step");
	chk_fail_halt: assert property (o_boot_fail |-> o_boot_done && !o_core_rst_n)
		else $error("core released after failure");
	chk_run_start: assert property (o_core_rst_n |-> o_start_addr == RAM_BASE_ADDR)
		else $error("start address wrong");

	cov_fail: cover property (o_boot_fail);
	cov_run: cover property ($rose(o_core_rst_n));
	cov_otp_img: cover property (o_otp_rd && o_otp_addr == OTP_IMAGE_ROW);
	cov_stall: cover property (o_ram.we && !i_ram_ready);
endmodule

`default_nettype wire

// *** testbench/qspi_flash_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module qspi_flash_model (
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic [3:0] i_dq,
	input wire logic [31:0] i_mem [0:15],
	output logic [3:0] o_dq
);
	logic [31:0] hdr;
	logic [7:0] cur;
	int edges;

	initial begin
		o_dq = 4'h0;
		hdr = 32'h0;
		edges = 0;
	end

	always @(negedge i_cs_n) edges = 0;

	// Command and address arrive on dq0, most significant bit first.
	always @(posedge i_sclk) begin
		if (!i_cs_n && edges < 32) begin
			hdr = {hdr[30:0], i_dq[0]};
		end
		edges = edges + 1;
	end

	// Outside the data phase the line toggles so stale data is never seen.
	always @(negedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n || edges < 40) begin
			o_dq = ~o_dq;
		end else begin
			cur = i_mem[((edges - 40) / 8) % 16][8 * (((edges - 40) / 2) % 4) +: 8];
			o_dq = ((edges - 40) % 2) ? cur[3:0] : cur[7:4];
		end
	end
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

`define CHK(name, exp, act) begin \
	comparisons++; \
	if ((act) !== (exp)) begin \
		error_cnt++; \
		$display("[ERR] %s exp %0h got %0h", name, exp, act); \
	end \
end

module tb_top;
	import boot_pkg::*;
	localparam int RST_CYCLES = 4;
	localparam int GPIO_COUNT = 16;
	logic i_mclk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_ce = 1'b1;
	logic i_otp_valid = 1'b0;
	logic [31:0] i_otp_data = 32'h0;
	logic i_ram_ready = 1'b1;
	logic ram_stall = 1'b0;
	logic [31:0] sec_word = 32'h0;
	logic [31:0] img [0:15];
	logic [3:0] fdq;
	logic [3:0] qdq;
	qspi_pins_s o_qspi;
	ram_wr_s o_ram;
	logic o_otp_rd, o_core_rst_n, o_boot_done, o_boot_fail;
	logic [10:0] o_otp_addr;
	logic [31:0] o_start_addr;
	logic [GPIO_COUNT-1:0] o_gpio_pulldown;
	logic [15:0] wr_addr [$];
	logic [31:0] wr_data [$];
	int error_cnt = 0;
	int comparisons = 0;

	always #5 i_mclk = ~i_mclk;
	assign qdq = (o_qspi.dq & o_qspi.dq_oe) | (fdq & ~o_qspi.dq_oe);

	boot_image_loader #(.RST_CYCLES(RST_CYCLES), .GPIO_COUNT(GPIO_COUNT)) i_boot_image_loader (
		.i_mclk, .i_nrst, .i_ce, .o_qspi, .i_qspi_dq(qdq), .o_otp_rd, .o_otp_addr,
		.i_otp_valid, .i_otp_data, .o_ram, .i_ram_ready, .o_gpio_pulldown,
		.o_core_rst_n, .o_start_addr, .o_boot_done, .o_boot_fail);
	qspi_flash_model i_qspi_flash_model (.i_sclk(o_qspi.sclk), .i_cs_n(o_qspi.cs_n),
		.i_dq(qdq), .i_mem(img), .o_dq(fdq));

	// OTP answers each request with a one-cycle pulse; RAM may be stalled.
	always @(posedge i_mclk) begin
		if (o_ram.we && i_ram_ready) begin
			wr_addr.push_back(o_ram.addr);
			wr_data.push_back(o_ram.data);
		end
		#1;
		i_otp_valid = o_otp_rd && !i_otp_valid;
		i_otp_data = (o_otp_addr == 11'h7FF) ? sec_word : img[o_otp_addr[3:0]];
		i_ram_ready = !ram_stall;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	task automatic final_report();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Reference checksum over count and body, worked bit by bit.
	function automatic logic [31:0] crc_img(input int s);
		logic [31:0] c;
		logic [7:0] b;
		c = 32'hFFFFFFFF;
		for (int k = 0; k < 4 * (s + 1); k++) begin
			b = img[k / 4][8 * (k % 4) +: 8];
			for (int j = 0; j < 8; j++) begin
				c = (c >> 1) ^ ((c[0] ^ b[j]) ? 32'hEDB88320 : 32'h0);
			end
		end
		return ~c;
	endfunction

	// Mode 0 good checksum, 1 skip marker, 2 corrupted checksum.
	task automatic load(input int s, input int mode);
		for (int k = 0; k < 16; k++) begin
			img[k] = 32'h1234ABCD ^ {8{4'(k)}} ^ 32'(k << 20);
		end
		img[0] = s;
		img[s + 1] = (mode == 1) ? 32'h0D15AB1E : crc_img(s) ^ {31'h0, mode == 2};
	endtask

	task automatic run_boot(input logic [31:0] sec, input int s, input logic ok, input logic stall);
		int n;
		sec_word = sec;
		ram_stall = stall;
		wr_addr.delete();
		wr_data.delete();
		i_nrst = 1'b0;
		tick(20);
		`CHK("pulldown", {GPIO_COUNT{1'b1}}, o_gpio_pulldown)
		i_nrst = 1'b1;
		n = 0;
		while (o_otp_rd !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		if (o_otp_rd !== 1'b1) begin
			error_cnt++;
			$display("[ERR] otp_rd exp 1 got timeout");
			final_report();
		end
		`CHK("sec_row", 11'h7FF, o_otp_addr)
		`CHK("rst_wait", 1'b1, n >= RST_CYCLES)
		if (stall) begin
			tick(600);
			for (int k = 0; k < 40; k++) begin
				`CHK("sclk_hold", 1'b0, o_qspi.sclk)
				tick(1);
			end
			ram_stall = 1'b0;
		end
		n = 0;
		while (o_boot_done !== 1'b1) begin
			tick(1);
			n++;
			if (n > 20000) begin
				error_cnt++;
				$display("[ERR] boot_done exp 1 got timeout");
				final_report();
			end
		end
		tick(3);
		`CHK("boot_fail", !ok, o_boot_fail)
		`CHK("core_run", ok, o_core_rst_n)
		`CHK("start_addr", 32'h0, o_start_addr)
		`CHK("word_cnt", s, wr_addr.size())
		foreach (wr_addr[k]) begin
			`CHK("ram_addr", 16'(k), wr_addr[k])
			`CHK("ram_data", img[k + 1], wr_data[k])
		end
		if (!sec[5]) begin
			`CHK("flash_cmd", 32'h6B000000, i_qspi_flash_model.hdr)
		end
	endtask

	task automatic sc_flash_stall();
		load(8, 0);
		run_boot(32'h0, 8, 1'b1, 1'b1);
	endtask

	task automatic sc_empty_image();
		load(0, 0);
		run_boot(32'h0, 0, 1'b1, 1'b0);
	endtask

	task automatic sc_skip_marker();
		load(2, 1);
		run_boot(32'h0, 2, 1'b1, 1'b0);
	endtask

	task automatic sc_bad_crc();
		load(3, 2);
		run_boot(32'hFFFFFFDF, 3, 1'b0, 1'b0);
	endtask

	task automatic sc_otp_boot();
		load(3, 0);
		run_boot(32'h00000020, 3, 1'b1, 1'b0);
	endtask

	initial begin
		tick(1);
		sc_flash_stall();
		sc_empty_image();
		sc_skip_marker();
		sc_bad_crc();
		sc_otp_boot();
		final_report();
	end
endmodule

bind boot_image_loader boot_loader_chk #(.RST_CYCLES(RST_CYCLES), .GPIO_COUNT(GPIO_COUNT)) i_chk (
	.i_mclk, .i_nrst, .o_qspi, .o_otp_rd, .o_otp_addr, .i_otp_valid, .i_otp_data,
	.o_ram, .i_ram_ready, .o_gpio_pulldown, .o_core_rst_n, .o_start_addr,
	.o_boot_done, .o_boot_fail);

`default_nettype wire
